// ===== rtl/ctsl_pkg.sv
// Overview of operation
// - Center mode reload: code 00 at period and zero match, 10 zero only.
// - Center period is 2 x prescaled clock x (period+1), duty (period+1-compare)/(period+1).
// - Counting mode bit: 0 edge-aligned, 1 center-aligned up/down.
// - Three independent events are derived from the external inputs.
// - Two-bit source select picks one of four external inputs per event.
// - Edge mode per event: 00 none, 01 rising, 10 falling, 11 both.
// - Level mode bit: 0 active while input high, 1 while low.
// - Each event gives an edge pulse and a level signal.
// - No input low-pass filter; filter fields have no effect.
// - Override select 1: trigger from event 1, value from event 2.
// - Trap select 1 connects trap to event 2; 0 disables trap.
// - Trap affects the output only while trap enable is 1.
// - Modulation select: 00 off, 01/10/11 use event 0/1/2.
// - Sync trap exit 1 aligns leaving trap to PWM period.
// - Modulation sync 1 applies modulation at period boundary, else immediately.
// - Modulation type 0 clears the status bit, 1 gates the output.
// - Passive level input sets inactive output polarity immediately.
// - Interrupt vector order: period, zero, compare up, compare down, ev0-2.
// - An interrupt pulse appears only for sources enabled with 1.
// - Diagnostic flags expose counter, hits, direction, override, trap, mod.
// - Four-bit prescaler divides module clock by 2 to the field value.
// - Edge mode wraps at period; set at compare+1, clear at count 1 after restart.
// - Center mode sets at compare+1 going up, clears at compare-1 down.
// - Edge mode loads period and compare shadows only at overflow.
package ctsl_pkg;
    localparam logic [7:0]  CTSL_STC_OFS  = 8'h00;
    localparam logic [7:0]  CTSL_TC_OFS   = 8'h04;
    localparam logic [7:0]  CTSL_INS1_OFS = 8'h08;
    localparam logic [7:0]  CTSL_INS2_OFS = 8'h0C;
    localparam logic [7:0]  CTSL_CMC_OFS  = 8'h10;
    localparam logic [7:0]  CTSL_INTE_OFS = 8'h14;
    localparam logic [7:0]  CTSL_PSC_OFS  = 8'h18;
    localparam logic [7:0]  CTSL_PRS_OFS  = 8'h1C;
    localparam logic [7:0]  CTSL_CRS_OFS  = 8'h20;
    localparam logic [7:0]  CTSL_CTRL_OFS = 8'h24;
    localparam logic [7:0]  CTSL_INTS_OFS = 8'h28;
    localparam logic [7:0]  CTSL_FLAG_OFS = 8'h2C;
    localparam int          CTSL_STM_LSB   = 1;
    localparam int          CTSL_TCM_BIT   = 0;
    localparam int          CTSL_CAPTURE_MODE_SELECT_BIT  = 3;
    localparam int          CTSL_TRAP_ENABLE_BIT = 17;
    localparam int          CTSL_SYNC_TRAP_EXIT_BIT = 21;
    localparam int          CTSL_SOFTWARE_TRAP_EXIT_BIT = 22;
    localparam int          CTSL_EMS_BIT   = 23;
    localparam int          CTSL_EMT_BIT   = 24;
    localparam int          CTSL_OFS_BIT   = 16;
    localparam int          CTSL_TS_BIT    = 17;
    localparam int          CTSL_MOS_LSB   = 18;
    localparam int          CTSL_EVLM_LSB  = 6;
    localparam int          CTSL_SRST_BIT  = 0;
    localparam logic [1:0]  CTSL_STM_ZERO  = 2'h2;
    localparam logic [31:0] CTSL_REG_RST   = 32'h0000_0000;
    localparam logic [15:0] CTSL_PRS_RST   = 16'hFFFF;
    localparam logic [15:0] CTSL_CRS_RST   = 16'h8000;

    typedef enum logic {
        CTSL_UP   = 1'b0,
        CTSL_DOWN = 1'b1
    } ctsl_dir_t;
endpackage

// ===== rtl/ctsl_slice.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ctsl_slice
    import ctsl_pkg::*;
#(
    parameter logic [15:0] INIT_COUNT  = 16'h0000,
    parameter logic        INIT_DIR    = 1'b0,
    parameter logic        INIT_STATUS = 1'b0
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ext_input_a,
    input  wire logic        ext_input_b,
    input  wire logic        ext_input_c,
    input  wire logic        ext_input_d,
    input  wire logic        passive_level_input,
    output logic             pwm_status_bit,
    output logic             pwm_out,
    output logic [6:0]       irq_status_output,
    output logic [23:0]      diag_flags
);
    // Bus slave and register file
    logic [31:0] stc_q, tc_q, ins1_q, ins2_q, cmc_q, inte_q, ctrl_q;
    logic [31:0] stc_d, tc_d, ins1_d, ins2_d, cmc_d, inte_d, ctrl_d;
    logic [3:0]  psc_q, psc_d;
    logic [15:0] prs_q, prs_d, crs_q, crs_d;
    logic [7:0]  addr_q, addr_d;
    logic        wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d;
    logic [31:0] rdata_q, rdata_d, rmux;
    logic        take;
    logic [6:0]  irq_q, irq_d;
    logic [23:0] flag_q, flag_d;

    assign take = hsel & htrans[1] & hready;

    always_comb begin
        rmux = 32'h0000_0000;
        case (addr_q)
            CTSL_STC_OFS:  rmux = stc_q;
            CTSL_TC_OFS:   rmux = tc_q;
            CTSL_INS1_OFS: rmux = ins1_q;
            CTSL_INS2_OFS: rmux = ins2_q;
            CTSL_CMC_OFS:  rmux = cmc_q;
            CTSL_INTE_OFS: rmux = inte_q;
            CTSL_PSC_OFS:  rmux = {28'h0000000, psc_q};
            CTSL_PRS_OFS:  rmux = {16'h0000, prs_q};
            CTSL_CRS_OFS:  rmux = {16'h0000, crs_q};
            CTSL_CTRL_OFS: rmux = ctrl_q;
            CTSL_INTS_OFS: rmux = {25'h0000000, irq_q};
            CTSL_FLAG_OFS: rmux = {8'h00, flag_q};
            default:       rmux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        stc_d = stc_q;
        tc_d = tc_q;
        ins1_d = ins1_q;
        ins2_d = ins2_q;
        cmc_d = cmc_q;
        inte_d = inte_q;
        psc_d = psc_q;
        prs_d = prs_q;
        crs_d = crs_q;
        // Soft reset bit is a one-cycle strobe
        ctrl_d = ctrl_q & ~(32'h1 << CTSL_SRST_BIT);
        addr_d = addr_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        rdy_d = 1'b1;
        rdata_d = rdata_q;
        if (wr_q) begin
            case (addr_q)
                CTSL_STC_OFS:  stc_d = hwdata;
                CTSL_TC_OFS:   tc_d = hwdata;
                CTSL_INS1_OFS: ins1_d = hwdata;
                CTSL_INS2_OFS: ins2_d = hwdata;
                CTSL_CMC_OFS:  cmc_d = hwdata;
                CTSL_INTE_OFS: inte_d = hwdata;
                CTSL_PSC_OFS:  psc_d = hwdata[3:0];
                CTSL_PRS_OFS:  prs_d = hwdata[15:0];
                CTSL_CRS_OFS:  crs_d = hwdata[15:0];
                CTSL_CTRL_OFS: ctrl_d = hwdata;
                default:       ctrl_d = ctrl_d;
            endcase
        end
        // One wait state on reads so a write just before is visible
        if (rd_q) begin
            rdata_d = rmux;
        end
        if (take) begin
            addr_d = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
            wr_d = hwrite;
            rd_d = ~hwrite;
            rdy_d = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stc_q <= CTSL_REG_RST;
            tc_q <= CTSL_REG_RST;
            ins1_q <= CTSL_REG_RST;
            ins2_q <= CTSL_REG_RST;
            cmc_q <= CTSL_REG_RST;
            inte_q <= CTSL_REG_RST;
            ctrl_q <= CTSL_REG_RST;
            psc_q <= 4'h0;
            prs_q <= CTSL_PRS_RST;
            crs_q <= CTSL_CRS_RST;
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rdy_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            stc_q <= stc_d;
            tc_q <= tc_d;
            ins1_q <= ins1_d;
            ins2_q <= ins2_d;
            cmc_q <= cmc_d;
            inte_q <= inte_d;
            ctrl_q <= ctrl_d;
            psc_q <= psc_d;
            prs_q <= prs_d;
            crs_q <= crs_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            rdy_q <= rdy_d;
            rdata_q <= rdata_d;
        end
    end

    assign hreadyout = rdy_q;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // Pin inputs: three stages, a change counts when stages 2 and 3 agree
    logic [4:0] s1_q, s2_q, s3_q, pin_q, pin_d;
    always_comb begin
        pin_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
            pin_q <= 5'h00;
        end else begin
            s1_q <= {passive_level_input, ext_input_d, ext_input_c,
                     ext_input_b, ext_input_a};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end

    // Event selector; filter fields in ins2 are never read
    logic [2:0] ev_sel, ev_prev_q, ev_edge, ev_lvl;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ev
            logic [1:0] src, em;
            assign src = ins1_q[2*g +: 2];
            assign em = ins2_q[2*g +: 2];
            assign ev_sel[g] = pin_q[src];
            assign ev_edge[g] = (em[0] & ev_sel[g] & ~ev_prev_q[g]) |
                                (em[1] & ~ev_sel[g] & ev_prev_q[g]);
            assign ev_lvl[g] = ev_sel[g] ^ ins2_q[CTSL_EVLM_LSB + g];
        end
    endgenerate

    // Timer kernel and output path
    logic [14:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d, pr_q, pr_d, cr_q, cr_d, top;
    ctsl_dir_t   dir_q, dir_d;
    logic        st_q, st_d, trap_q, trap_d, mod_q, mod_d, out_q, out_d;
    logic        tick, center, per_hit, zero_hit, pbound, reload, srst;
    logic        set_ev, clr_ev, cu_ev, cd_ev, trap_src, mod_src, ovr;
    logic [1:0]  modulation_select;

    assign center = tc_q[CTSL_TCM_BIT];
    assign srst = ctrl_q[CTSL_SRST_BIT];
    assign tick = (pre_q == 15'((16'h1 << psc_q) - 16'h1));
    assign top = center ? 16'(pr_q + 16'h1) : pr_q;
    assign per_hit = tick & (dir_q == CTSL_UP) & (cnt_q == top);
    assign zero_hit = tick & (cnt_q == 16'h0000) &
                      (center ? (dir_q == CTSL_DOWN) : 1'b1);
    assign pbound = center ? zero_hit : per_hit;
    assign reload = center ? ((stc_q[CTSL_STM_LSB +: 2] == CTSL_STM_ZERO) ?
                    zero_hit : (per_hit | zero_hit)) : per_hit;
    assign trap_src = cmc_q[CTSL_TS_BIT] & ev_lvl[2];
    assign modulation_select = cmc_q[CTSL_MOS_LSB +: 2];
    // Decoded per code so no index runs past the three events
    assign mod_src = ((modulation_select == 2'h1) & ev_lvl[0]) |
                     ((modulation_select == 2'h2) & ev_lvl[1]) |
                     ((modulation_select == 2'h3) & ev_lvl[2]);
    assign ovr = cmc_q[CTSL_OFS_BIT] & ev_edge[1];

    always_comb begin
        pre_d = tick ? 15'h0000 : 15'(pre_q + 15'h1);
        cnt_d = cnt_q;
        dir_d = dir_q;
        pr_d = reload ? prs_q : pr_q;
        cr_d = reload ? crs_q : cr_q;
        set_ev = 1'b0;
        clr_ev = 1'b0;
        if (tick) begin
            if (!center) begin
                cnt_d = per_hit ? 16'h0000 : 16'(cnt_q + 16'h1);
                dir_d = CTSL_UP;
            end else if (dir_q == CTSL_UP) begin
                // Turn at period+1 and at zero: two ramps per PWM period
                dir_d = per_hit ? CTSL_DOWN : CTSL_UP;
                cnt_d = per_hit ? 16'(cnt_q - 16'h1) : 16'(cnt_q + 16'h1);
            end else begin
                dir_d = zero_hit ? CTSL_UP : CTSL_DOWN;
                cnt_d = zero_hit ? 16'(cnt_q + 16'h1) : 16'(cnt_q - 16'h1);
            end
            set_ev = (dir_d == CTSL_UP) & (cnt_d == 16'(cr_q + 16'h1));
            clr_ev = center ? ((dir_d == CTSL_DOWN) &
                     (cnt_d == 16'(cr_q - 16'h1))) : (cnt_d == 16'h0001);
        end
        st_d = set_ev ? 1'b1 : (clr_ev ? 1'b0 : st_q);
        mod_d = tc_q[CTSL_EMS_BIT] ? (pbound ? mod_src : mod_q) : mod_src;
        if (mod_q & ~tc_q[CTSL_EMT_BIT]) begin
            st_d = 1'b0;
        end
        if (ovr) begin
            st_d = ev_lvl[2];
        end
        // Software trap exit and capture mode bits are left unused
        if (!tc_q[CTSL_TRAP_ENABLE_BIT]) begin
            trap_d = 1'b0;
        end else if (trap_src) begin
            trap_d = 1'b1;
        end else begin
            trap_d = trap_q & tc_q[CTSL_SYNC_TRAP_EXIT_BIT] & ~pbound;
        end
        out_d = pin_q[4] ^ (st_q & ~trap_q &
                ~(mod_q & tc_q[CTSL_EMT_BIT]));
        if (srst) begin
            pre_d = 15'h0000;
            cnt_d = INIT_COUNT;
            dir_d = ctsl_dir_t'(INIT_DIR);
            st_d = INIT_STATUS;
            trap_d = 1'b0;
            mod_d = 1'b0;
            out_d = pin_q[4];
        end
        cu_ev = set_ev;
        cd_ev = center & clr_ev;
        // Event 0 sits above event 2, so the edge vector is reversed here
        irq_d = {per_hit, zero_hit, cu_ev, cd_ev, ev_edge[0], ev_edge[1],
                 ev_edge[2]} & inte_q[6:0];
        flag_d = {cnt_q, cu_ev, per_hit, zero_hit, dir_q == CTSL_DOWN,
                  ovr, ev_lvl[2], trap_q, mod_q};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 15'h0000;
            cnt_q <= INIT_COUNT;
            dir_q <= ctsl_dir_t'(INIT_DIR);
            pr_q <= CTSL_PRS_RST;
            cr_q <= CTSL_CRS_RST;
            st_q <= INIT_STATUS;
            trap_q <= 1'b0;
            mod_q <= 1'b0;
            out_q <= 1'b0;
            ev_prev_q <= 3'h0;
            irq_q <= 7'h00;
            flag_q <= 24'h000000;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            pr_q <= pr_d;
            cr_q <= cr_d;
            st_q <= st_d;
            trap_q <= trap_d;
            mod_q <= mod_d;
            out_q <= out_d;
            ev_prev_q <= ev_sel;
            irq_q <= irq_d;
            flag_q <= flag_d;
        end
    end

    assign pwm_status_bit = st_q;
    assign pwm_out = out_q;
    assign irq_status_output = irq_q;
    assign diag_flags = flag_q;

    // Checks
    sequence s_peak;
        center & per_hit & !srst;
    endsequence
    sequence s_turned;
        (dir_q == CTSL_DOWN) ##0 (cnt_q == 16'($past(cnt_q) - 16'h1));
    endsequence
    property p_center_turn;
        @(posedge hclk) disable iff (!hresetn) s_peak |=> s_turned;
    endproperty
    a_center_turn: assert property (p_center_turn)
        else $error("center counter did not turn at period plus one");
    property p_edge_wrap;
        @(posedge hclk) disable iff (!hresetn)
        (!center & per_hit & !srst) |=> (cnt_q == 16'h0000);
    endproperty
    a_edge_wrap: assert property (p_edge_wrap)
        else $error("edge counter did not wrap at period");
    property p_edge_reload;
        @(posedge hclk) disable iff (!hresetn)
        (!center & tick & (cnt_q != pr_q)) |=> $stable(pr_q);
    endproperty
    a_edge_reload: assert property (p_edge_reload)
        else $error("period reloaded away from overflow");
    property p_stm_zero;
        @(posedge hclk) disable iff (!hresetn)
        (center & per_hit & (stc_q[2:1] == CTSL_STM_ZERO)) |=> $stable(pr_q);
    endproperty
    a_stm_zero: assert property (p_stm_zero)
        else $error("reload at period match with zero-only select");
    property p_trap_out;
        @(posedge hclk) disable iff (!hresetn)
        (trap_q & tc_q[CTSL_TRAP_ENABLE_BIT] & !srst) |=> (out_q == $past(pin_q[4]));
    endproperty
    a_trap_out: assert property (p_trap_out)
        else $error("output not passive during trap");
    property p_irq_mask;
        @(posedge hclk) disable iff (!hresetn)
        (irq_q != 7'h00) |-> ((irq_q & ~$past(inte_q[6:0])) == 7'h00);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt pulse from a disabled source");
    property p_override;
        @(posedge hclk) disable iff (!hresetn)
        (ovr & !srst) |=> (st_q == $past(ev_lvl[2]));
    endproperty
    a_override: assert property (p_override)
        else $error("override value not taken from event 2");
    property p_sync_exit;
        @(posedge hclk) disable iff (!hresetn)
        (trap_q & tc_q[CTSL_TRAP_ENABLE_BIT] & tc_q[CTSL_SYNC_TRAP_EXIT_BIT] & !pbound
         & !srst) |=> trap_q;
    endproperty
    a_sync_exit: assert property (p_sync_exit)
        else $error("trap left away from period boundary");
    property p_mod_clear;
        @(posedge hclk) disable iff (!hresetn)
        (mod_q & !tc_q[CTSL_EMT_BIT] & !ovr & !srst) |=> !st_q;
    endproperty
    a_mod_clear: assert property (p_mod_clear)
        else $error("modulation did not clear status");
    property p_mod_sync;
        @(posedge hclk) disable iff (!hresetn)
        (tc_q[CTSL_EMS_BIT] & !pbound & !srst) |=> $stable(mod_q);
    endproperty
    a_mod_sync: assert property (p_mod_sync)
        else $error("synchronised modulation changed off the boundary");
endmodule // ctsl_slice

// ===== sim/ctsl_partner.sv
`timescale 1ns/1ps
module ctsl_partner (
    input  wire logic       hclk,
    input  wire logic [3:0] ev_req,
    input  wire logic       pwm_out,
    output logic            ext_input_a,
    output logic            ext_input_b,
    output logic            ext_input_c,
    output logic            ext_input_d,
    output int              gate_cycles
);
    // Event lines move just after an edge, the way a board-level driver would
    initial begin
        {ext_input_d, ext_input_c, ext_input_b, ext_input_a} = 4'h0;
        gate_cycles = 0;
    end
    // The gate driver counts cycles in which the switch is commanded on
    always @(posedge hclk) begin
        {ext_input_d, ext_input_c, ext_input_b, ext_input_a} <= ev_req;
        gate_cycles <= gate_cycles + int'(pwm_out === 1'b1);
    end
endmodule // ctsl_partner

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ctsl_pkg::*;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
    } ctsl_row_t;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        ext_input_a;
    logic        ext_input_b;
    logic        ext_input_c;
    logic        ext_input_d;
    logic        passive_level_input;
    logic        pwm_status_bit;
    logic        pwm_out;
    logic [6:0]  irq_status_output;
    logic [23:0] diag_flags;
    logic [3:0]  ev_req;
    logic [31:0] rd;
    int          gate_cycles;
    int          err_total;
    int          total_checks;
    int          cyc;
    int          n_ev0;
    int          n_other;
    int          per, hi, g, pm, ne, nf, o0;
    ctsl_row_t   rows [0:24] = '{
        '{1'b0, 12'h000, 32'h0}, '{1'b0, 12'h004, 32'h0},
        '{1'b0, 12'h008, 32'h0}, '{1'b0, 12'h00C, 32'h0},
        '{1'b0, 12'h010, 32'h0}, '{1'b0, 12'h014, 32'h0},
        '{1'b0, 12'h018, 32'h0}, '{1'b0, 12'h01C, 32'hFFFF},
        '{1'b0, 12'h020, 32'h8000}, '{1'b0, 12'h028, 32'h0},
        '{1'b0, 12'h030, 32'h0}, '{1'b1, 12'h000, 32'h4},
        '{1'b0, 12'h000, 32'h4}, '{1'b1, 12'h018, 32'h1},
        '{1'b0, 12'h018, 32'h1}, '{1'b1, 12'h01C, 32'h9},
        '{1'b0, 12'h01C, 32'h9}, '{1'b1, 12'h020, 32'h4},
        '{1'b0, 12'h020, 32'h4}, '{1'b1, 12'h028, 32'h7F},
        '{1'b0, 12'h028, 32'h0}, '{1'b1, 12'h030, 32'h5},
        '{1'b0, 12'h030, 32'h0}, '{1'b1, 12'h100, 32'h5},
        '{1'b0, 12'h100, 32'h0}};

    // Soft reset starts the count near overflow so new shadows load fast
    ctsl_slice #(.INIT_COUNT(16'hFFF0), .INIT_DIR(1'b0), .INIT_STATUS(1'b0))
    uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ext_input_a(ext_input_a),
        .ext_input_b(ext_input_b), .ext_input_c(ext_input_c),
        .ext_input_d(ext_input_d), .passive_level_input(passive_level_input),
        .pwm_status_bit(pwm_status_bit), .pwm_out(pwm_out),
        .irq_status_output(irq_status_output), .diag_flags(diag_flags));

    ctsl_partner partner (.hclk(hclk), .ev_req(ev_req), .pwm_out(pwm_out),
        .ext_input_a(ext_input_a), .ext_input_b(ext_input_b),
        .ext_input_c(ext_input_c), .ext_input_d(ext_input_d),
        .gate_cycles(gate_cycles));

    always #2 hclk = ~hclk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        n_ev0 <= n_ev0 + int'(irq_status_output[2] === 1'b1);
        n_other <= n_other + int'(irq_status_output[6:3] !== 4'h0)
            + int'(irq_status_output[1:0] !== 2'h0);
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Single transfer; the wait on hready has no cycle count of its own
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    task automatic measure(output int per, output int hi, output int g,
                           output int pm);
        logic p;
        int   g0;
        p = 1'b1;
        while (!(p === 1'b0 && pwm_status_bit === 1'b1)) begin
            p = pwm_status_bit;
            @(posedge hclk);
        end
        per = 0;
        hi = 0;
        pm = 0;
        g0 = gate_cycles;
        do begin
            hi += int'(pwm_status_bit === 1'b1);
            pm += int'(irq_status_output[6] === 1'b1);
            per++;
            p = pwm_status_bit;
            @(posedge hclk);
        end while (!(p === 1'b0 && pwm_status_bit === 1'b1));
        g = gate_cycles - g0;
    endtask

    task automatic window(output int st, output int g);
        int g0;
        g0 = gate_cycles;
        st = 0;
        repeat (40) begin
            st += int'(pwm_status_bit === 1'b1);
            @(posedge hclk);
        end
        g = gate_cycles - g0;
    endtask

    // Rising then falling edge on one line; the synchroniser needs ~4 cycles
    task automatic pulse(input int idx, output int r, output int f);
        int c0;
        c0 = n_ev0;
        ev_req[idx] <= 1'b1;
        tick(12);
        r = n_ev0 - c0;
        c0 = n_ev0;
        ev_req[idx] <= 1'b0;
        tick(12);
        f = n_ev0 - c0;
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        passive_level_input = 1'b0;
        ev_req = 4'h0;
        err_total = 0;
        total_checks = 0;
        cyc = 0;
        n_ev0 = 0;
        n_other = 0;
        tick(12);
        hresetn <= 1'b1;
        tick(1);
        foreach (rows[i]) begin
            ahb(rows[i].w, {20'h0, rows[i].a}, rows[i].d, rd);
            if (!rows[i].w) chk(rd, rows[i].d);
        end
        $display("register table done");
        ahb(1'b1, 32'h14, 32'h40, rd);
        ahb(1'b1, 32'h24, 32'h1, rd);
        tick(60);
        measure(per, hi, g, pm);
        chk(per, 20);
        chk(hi, 12);
        chk(g, 12);
        chk(pm, 1);
        passive_level_input <= 1'b1;
        tick(10);
        measure(per, hi, g, pm);
        chk(g, 8);
        passive_level_input <= 1'b0;
        $display("edge-aligned timing done");
        ahb(1'b1, 32'h08, 32'h20, rd);
        ahb(1'b1, 32'h10, 32'h20000, rd);
        ahb(1'b1, 32'h04, 32'h20000, rd);
        ev_req[2] <= 1'b1;
        tick(12);
        measure(per, hi, g, pm);
        chk(g, 0);
        chk(diag_flags[1], 1'b1);
        ahb(1'b1, 32'h04, 32'h0, rd);
        tick(12);
        measure(per, hi, g, pm);
        chk(g, 12);
        ahb(1'b1, 32'h0C, 32'h100, rd);
        ahb(1'b1, 32'h04, 32'h20000, rd);
        ev_req[2] <= 1'b0;
        tick(12);
        chk(diag_flags[1], 1'b1);
        ev_req[2] <= 1'b1;
        tick(12);
        chk(diag_flags[1], 1'b0);
        ahb(1'b1, 32'h04, 32'h220000, rd);
        ev_req[2] <= 1'b0;
        tick(12);
        ev_req[2] <= 1'b1;
        while (diag_flags[1] !== 1'b0) tick(1);
        chk(diag_flags[23:8], 16'h0000);
        ahb(1'b1, 32'h04, 32'h0, rd);
        ev_req[2] <= 1'b0;
        $display("trap done");
        ahb(1'b1, 32'h08, 32'h0, rd);
        ahb(1'b1, 32'h0C, 32'h0, rd);
        ahb(1'b1, 32'h10, 32'h40000, rd);
        ahb(1'b1, 32'h04, 32'h800000, rd);
        ev_req[0] <= 1'b1;
        while (diag_flags[0] !== 1'b1) tick(1);
        chk(diag_flags[23:8], 16'h0000);
        tick(12);
        window(hi, g);
        chk(hi, 0);
        chk(diag_flags[0], 1'b1);
        ahb(1'b1, 32'h04, 32'h1000000, rd);
        tick(4);
        window(hi, g);
        chk(32'(hi != 0), 1);
        chk(g, 0);
        ahb(1'b1, 32'h04, 32'h0, rd);
        ahb(1'b1, 32'h10, 32'h0, rd);
        tick(4);
        window(hi, g);
        chk(32'(hi != 0), 1);
        ahb(1'b1, 32'h08, 32'h24, rd);
        ahb(1'b1, 32'h0C, 32'h4, rd);
        ahb(1'b1, 32'h10, 32'h50000, rd);
        ev_req[2] <= 1'b1;
        tick(12);
        ev_req[1] <= 1'b1;
        window(hi, g);
        chk(hi, 1);
        ahb(1'b1, 32'h10, 32'h0, rd);
        ev_req <= 4'h0;
        $display("modulation done");
        ahb(1'b1, 32'h04, 32'h1, rd);
        tick(100);
        measure(per, hi, g, pm);
        chk(per, 40);
        ahb(1'b1, 32'h1C, 32'h4, rd);
        tick(100);
        measure(per, hi, g, pm);
        chk(per, 20);
        ahb(1'b1, 32'h04, 32'h0, rd);
        $display("center-aligned done");
        ahb(1'b1, 32'h14, 32'h7, rd);
        tick(4);
        o0 = n_other;
        for (int s = 0; s < 4; s++) begin
            ahb(1'b1, 32'h08, 32'(s), rd);
            ahb(1'b1, 32'h0C, 32'h3, rd);
            pulse(s, ne, nf);
            chk(ne + nf, 2);
            pulse((s + 1) % 4, ne, nf);
            chk(ne + nf, 0);
        end
        ahb(1'b1, 32'h08, 32'h0, rd);
        for (int em = 0; em < 4; em++) begin
            ahb(1'b1, 32'h0C, 32'(em), rd);
            pulse(0, ne, nf);
            chk(ne, em & 1);
            chk(nf, (em >> 1) & 1);
        end
        chk(n_other - o0, 0);
        $display("events done");
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        ahb(1'b0, 32'h1C, 32'h0, rd);
        chk(rd, {16'h0000, CTSL_PRS_RST});
        $display("reset done");
        end_of_test();
    end
endmodule // tb_top
